// ### cmmc_pkg.sv
// Package for the processor-module miscellaneous control bank.
// Assumes a classic Wishbone slave with byte-wide data in the low lane.
package cmmc_pkg;
  localparam int unsigned ADDR_W = 40;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] MISC_READBACK_ADDR = 40'hFFC4000000;
  localparam logic [ADDR_W-1:0] MISC_LINE_DRIVE_ADDR = 40'hFFC5000000;
  localparam logic [ADDR_W-1:0] SYS_RESET_TRIG_ADDR = 40'hFFC6000000;
  localparam logic [ADDR_W-1:0] SROM_POWER_ADDR = 40'hFFC7000000;
  // Line drive control bit positions
  localparam int unsigned B_CPU1_OWNER = 7;
  localparam int unsigned B_CPU0_OWNER = 6;
  localparam int unsigned B_OWNER_LINE = 5;
  localparam int unsigned B_RUN_LINE = 4;
  localparam int unsigned B_FLASH_WE = 3;
  localparam int unsigned B_BAD_LINE = 2;
  // Serial ROM / power status bit positions
  localparam int unsigned B_STP_LED = 7;
  localparam int unsigned B_PWR_A = 6;
  localparam int unsigned B_PWR_B = 5;
  localparam int unsigned B_CAB_HI = 4;
  localparam int unsigned B_CAB_LO = 3;
  localparam int unsigned B_SROM_TX = 2;
  localparam int unsigned B_SROM_RX = 1;
  localparam int unsigned B_SERIAL_ROM_CLOCK_BIT = 0;
  localparam logic [7:0] LINE_DRIVE_RST = 8'h00;
  localparam logic SROM_TX_RST = 1'b1;
  localparam logic SERIAL_ROM_CLOCK_BIT_RST = 1'b1;
  // Reset sequence timing
  localparam int unsigned LOCAL_RST_CYCLES = 128;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned BP_RST_US = 16;
  localparam int unsigned BP_RST_CYCLES = BP_RST_US * CLK_MHZ;
  localparam int unsigned CNT_W = 11;
  typedef enum logic [1:0] {
    CMMC_CAB_MAIN  = 2'b00,
    CMMC_CAB_RIGHT = 2'b01,
    CMMC_CAB_LEFT  = 2'b10,
    CMMC_CAB_LOOP  = 2'b11
  } cmmc_cab_t;
  typedef enum logic [1:0] {
    CMMC_RS_IDLE  = 2'b00,
    CMMC_RS_LOCAL = 2'b01,
    CMMC_RS_BP    = 2'b10
  } cmmc_rs_state_t;
endpackage : cmmc_pkg

// ### cmmc_rst_if.sv
// Start and status between the register bank and the reset sequencer.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface cmmc_rst_if;
  logic start;
  logic busy;
  modport bank (output start, input busy);
  modport seq  (input start, output busy);
endinterface : cmmc_rst_if

// ### cmmc_rst_seq.sv
// System reset sequencer: local reset then backplane reset.
// Assumes a one-cycle start pulse on the same clock.
`timescale 1ns/1ps
module cmmc_rst_seq
  import cmmc_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  reset_i,
  cmmc_rst_if.seq    ctl,
  output logic       local_reset_o,
  output logic       backplane_reset_o
);
  import cmmc_pkg::*;
  typedef struct packed {
    cmmc_rs_state_t st;
    logic [CNT_W-1:0] cnt;
  } cmmc_seq_t;
  cmmc_seq_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    unique case (s_r.st)
      CMMC_RS_IDLE: begin
        if (ctl.start) begin
          s_nxt.st = CMMC_RS_LOCAL;
          s_nxt.cnt = CNT_W'(LOCAL_RST_CYCLES - 1);
        end
      end
      CMMC_RS_LOCAL: begin
        if (s_r.cnt == '0) begin
          s_nxt.st = CMMC_RS_BP;
          s_nxt.cnt = CNT_W'(BP_RST_CYCLES - 1);
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      CMMC_RS_BP: begin
        if (s_r.cnt == '0) begin
          s_nxt.st = CMMC_RS_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      default: s_nxt.st = CMMC_RS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign local_reset_o = (s_r.st == CMMC_RS_LOCAL);
  assign backplane_reset_o = (s_r.st == CMMC_RS_BP);
  assign ctl.busy = (s_r.st != CMMC_RS_IDLE);

  // High cycles of the local reset, counted for the length check
  logic [7:0] loc_run_r;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      loc_run_r <= '0;
    end else if (local_reset_o) begin
      loc_run_r <= loc_run_r + 8'h01;
    end else begin
      loc_run_r <= '0;
    end
  end

  property p_local_len;
    @(posedge clk_i) disable iff (reset_i)
      $fell(local_reset_o) |-> (loc_run_r == 8'(LOCAL_RST_CYCLES)) && backplane_reset_o;
  endproperty
  a_local_len: assert property (p_local_len) else $error("local reset length wrong");
endmodule : cmmc_rst_seq

// ### cmmc_sync.sv
// Two-flop synchroniser bank for external status pins.
// Assumes inputs asynchronous to clk_i.
`timescale 1ns/1ps
module cmmc_sync #(
  parameter int unsigned W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  output logic [W-1:0]      sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cmmc_sy_t;
  cmmc_sy_t s_r, s_nxt;
  always_comb begin
    s_nxt.s1 = async_i;
    s_nxt.s2 = s_r.s1;
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign sync_o = s_r.s2;
endmodule : cmmc_sync

// ### cmmc_top.sv
// Processor-module miscellaneous control bank on a classic Wishbone slave.
// Assumes byte data in dat[7:0], sel[0] qualifying writes, one clock.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
module cmmc_top
  import cmmc_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       reset_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [cmmc_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [cmmc_pkg::DATA_W-1:0] wb_dat_i,
  input  wire logic [3:0]                 wb_sel_i,
  output logic [cmmc_pkg::DATA_W-1:0]     wb_dat_o,
  output logic                            wb_ack_o,
  output logic                            wb_err_o,
  input  wire logic                       flash_wr_req_i,
  output logic                            flash_wr_o,
  input  wire logic                       run_line_i,
  input  wire logic                       secure_line_i,
  input  wire logic                       power_unit_a_i,
  input  wire logic                       power_unit_b_status_i,
  input  wire logic                       serial_rom_data_i,
  output logic                            serial_rom_data_o,
  output logic                            serial_rom_data_oe_o,
  output logic                            serial_rom_clock_o,
  output logic                            console_owner_line_drive_o,
  output logic                            run_line_drive_o,
  output logic                            backplane_failed_module_line_o,
  output logic                            local_reset_o,
  output logic                            backplane_reset_line_o,
  output logic                            selftest_passed_led_o,
  output logic                            power_fail_irq_o,
  input  wire logic                       ps_tx_i,
  output logic                            ps_rx_o,
  output logic [2:0]                      cab_tx_o,
  input  wire logic [2:0]                 cab_rx_i
);
  import cmmc_pkg::*;

  typedef struct packed {
    logic [7:0]  line_drive;
    logic        stp_led;
    logic        pf_irq_en;
    cmmc_cab_t   cab;
    logic        srom_tx;
    logic        serial_rom_clock_bit;
    logic        pwr_a_last;
    logic        pf_irq;
    logic        ack;
    logic        err;
    logic [7:0]  rdata;
  } cmmc_state_t;

  cmmc_state_t s_r, s_nxt;
  cmmc_rst_if  rst_bus ();

  logic [2:0] sync_in;
  logic       pwr_a_s;
  logic       pwr_b_s;
  logic       srom_rx_s;
  logic       req;
  logic       wr;
  logic       hit_rb;
  logic       hit_ld;
  logic       hit_rt;
  logic       hit_sr;

  function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ref_a);
    is_addr = (a == ref_a);
  endfunction : is_addr

  cmmc_sync #(.W(3)) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i ({power_unit_a_i, power_unit_b_status_i, serial_rom_data_i}),
    .sync_o  (sync_in)
  );
  assign pwr_a_s   = sync_in[2];
  assign pwr_b_s   = sync_in[1];
  assign srom_rx_s = sync_in[0];

  cmmc_rst_seq u_rst (
    .clk_i             (clk_i),
    .reset_i           (reset_i),
    .ctl               (rst_bus.seq),
    .local_reset_o     (local_reset_o),
    .backplane_reset_o (backplane_reset_line_o)
  );

  assign req    = wb_cyc_i && wb_stb_i && !s_r.ack && !s_r.err;
  assign wr     = req && wb_we_i && wb_sel_i[0];
  assign hit_rb = is_addr(wb_adr_i, MISC_READBACK_ADDR);
  assign hit_ld = is_addr(wb_adr_i, MISC_LINE_DRIVE_ADDR);
  assign hit_rt = is_addr(wb_adr_i, SYS_RESET_TRIG_ADDR);
  assign hit_sr = is_addr(wb_adr_i, SROM_POWER_ADDR);

  // Start only from idle; a retrigger during a running sequence is dropped
  assign rst_bus.start = wr && hit_rt && !rst_bus.busy;

  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.err = 1'b0;
    s_nxt.pwr_a_last = pwr_a_s;
    // Change of power unit A is sticky; set beats clear
    if (s_r.pf_irq_en && (pwr_a_s != s_r.pwr_a_last)) begin
      s_nxt.pf_irq = 1'b1;
    end else if (wr && hit_sr && !wb_dat_i[B_PWR_A]) begin
      s_nxt.pf_irq = 1'b0;
    end
    if (req) begin
      if (hit_rb || hit_ld || hit_rt || hit_sr) begin
        s_nxt.ack = 1'b1;
      end else begin
        s_nxt.err = 1'b1;
      end
      s_nxt.rdata = '0;
      if (!wb_we_i && hit_rb) begin
        s_nxt.rdata[B_CPU1_OWNER] = s_r.line_drive[B_CPU1_OWNER];
        s_nxt.rdata[B_CPU0_OWNER] = s_r.line_drive[B_CPU0_OWNER];
        s_nxt.rdata[B_RUN_LINE] = run_line_i;
        s_nxt.rdata[B_FLASH_WE] = secure_line_i;
      end
      if (!wb_we_i && hit_sr) begin
        s_nxt.rdata[B_STP_LED]  = s_r.stp_led;
        s_nxt.rdata[B_PWR_A]    = pwr_a_s;
        s_nxt.rdata[B_PWR_B]    = pwr_b_s;
        s_nxt.rdata[B_CAB_HI:B_CAB_LO] = s_r.cab;
        s_nxt.rdata[B_SROM_RX]  = srom_rx_s;
      end
    end
    if (wr && hit_ld) begin
      s_nxt.line_drive = wb_dat_i[7:0];
    end
    if (wr && hit_sr) begin
      s_nxt.stp_led   = wb_dat_i[B_STP_LED];
      s_nxt.pf_irq_en = wb_dat_i[B_PWR_A];
      s_nxt.cab       = cmmc_cab_t'(wb_dat_i[B_CAB_HI:B_CAB_LO]);
      s_nxt.srom_tx   = wb_dat_i[B_SROM_TX];
      s_nxt.serial_rom_clock_bit  = wb_dat_i[B_SERIAL_ROM_CLOCK_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_r <= '0;
      s_r.line_drive <= LINE_DRIVE_RST;
      s_r.srom_tx <= SROM_TX_RST;
      s_r.serial_rom_clock_bit <= SERIAL_ROM_CLOCK_BIT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_ack_o = s_r.ack;
  assign wb_err_o = s_r.err;
  // Reset trigger reads zero: nothing behind it
  assign wb_dat_o = {{(DATA_W-8){1'b0}}, s_r.rdata};
  assign console_owner_line_drive_o = s_r.line_drive[B_OWNER_LINE];
  assign run_line_drive_o = s_r.line_drive[B_RUN_LINE];
  assign flash_wr_o = flash_wr_req_i && s_r.line_drive[B_FLASH_WE];
  assign backplane_failed_module_line_o = s_r.line_drive[B_BAD_LINE];
  assign selftest_passed_led_o = s_r.stp_led;
  assign power_fail_irq_o = s_r.pf_irq;
  // Open drain: drive low only, release for high so the ROM can answer
  assign serial_rom_data_o = 1'b0;
  assign serial_rom_data_oe_o = !s_r.srom_tx;
  assign serial_rom_clock_o = s_r.serial_rom_clock_bit;

  always_comb begin
    cab_tx_o = 3'h7;
    ps_rx_o = 1'b1;
    unique case (s_r.cab)
      CMMC_CAB_MAIN: begin
        cab_tx_o[0] = ps_tx_i;
        ps_rx_o = cab_rx_i[0];
      end
      CMMC_CAB_RIGHT: begin
        cab_tx_o[1] = ps_tx_i;
        ps_rx_o = cab_rx_i[1];
      end
      CMMC_CAB_LEFT: begin
        cab_tx_o[2] = ps_tx_i;
        ps_rx_o = cab_rx_i[2];
      end
      CMMC_CAB_LOOP: begin
        ps_rx_o = ps_tx_i;
      end
    endcase
  end

  property p_flash_gate;
    @(posedge clk_i) disable iff (reset_i) flash_wr_o |-> s_r.line_drive[B_FLASH_WE];
  endproperty
  a_flash_gate: assert property (p_flash_gate) else $error("flash write while protected");

  property p_bad_follow;
    @(posedge clk_i) disable iff (reset_i)
      (wr && hit_ld) |=> (backplane_failed_module_line_o == $past(wb_dat_i[B_BAD_LINE]));
  endproperty
  a_bad_follow: assert property (p_bad_follow) else $error("bad line not following write");

  property p_owner_rb;
    @(posedge clk_i) disable iff (reset_i)
      (req && !wb_we_i && hit_rb) |=>
        (wb_dat_o[B_CPU1_OWNER:B_CPU0_OWNER] == s_r.line_drive[B_CPU1_OWNER:B_CPU0_OWNER]);
  endproperty
  a_owner_rb: assert property (p_owner_rb) else $error("owner readback mismatch");

  property p_start;
    @(posedge clk_i) disable iff (reset_i)
      (wr && hit_rt && !rst_bus.busy) |=> local_reset_o;
  endproperty
  a_start: assert property (p_start) else $error("reset sequence did not start");

  property p_loop;
    @(posedge clk_i) disable iff (reset_i) (s_r.cab == CMMC_CAB_LOOP) |-> (ps_rx_o == ps_tx_i);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback broken");

  property p_pwr_a_live;
    @(posedge clk_i) disable iff (reset_i)
      (req && !wb_we_i && hit_sr) |=> (wb_dat_o[B_PWR_A] == $past(pwr_a_s));
  endproperty
  a_pwr_a_live: assert property (p_pwr_a_live) else $error("power A not live");

  property p_ack_drop;
    @(posedge clk_i) disable iff (reset_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held two cycles");

  property p_led;
    @(posedge clk_i) disable iff (reset_i)
      (wr && hit_sr) |=> (selftest_passed_led_o == $past(wb_dat_i[B_STP_LED]));
  endproperty
  a_led: assert property (p_led) else $error("LED not following write");

  // Fixed one-cycle answer; masters may still wait on ack
  property p_ack_latency;
    @(posedge clk_i) disable iff (reset_i) req |=> (wb_ack_o || wb_err_o);
  endproperty
  a_ack_latency: assert property (p_ack_latency) else $error("bus answer late");

  property p_err_unmapped;
    @(posedge clk_i) disable iff (reset_i)
      (req && !(hit_rb || hit_ld || hit_rt || hit_sr)) |=> (wb_err_o && !wb_ack_o);
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access accepted");

  property p_owner_line;
    @(posedge clk_i) disable iff (reset_i)
      (wr && hit_ld) |=> (console_owner_line_drive_o == $past(wb_dat_i[B_OWNER_LINE]));
  endproperty
  a_owner_line: assert property (p_owner_line) else $error("owner line wrong");

  property p_run_line;
    @(posedge clk_i) disable iff (reset_i)
      (wr && hit_ld) |=> (run_line_drive_o == $past(wb_dat_i[B_RUN_LINE]));
  endproperty
  a_run_line: assert property (p_run_line) else $error("run line wrong");

  property p_flash_pass;
    @(posedge clk_i) disable iff (reset_i)
      (flash_wr_req_i && s_r.line_drive[B_FLASH_WE]) |-> flash_wr_o;
  endproperty
  a_flash_pass: assert property (p_flash_pass) else $error("flash write blocked");

  property p_trig_nostore;
    @(posedge clk_i) disable iff (reset_i)
      (wr && hit_rt) |=>
        ($stable(s_r.line_drive) && $stable(s_r.stp_led) && $stable(s_r.cab));
  endproperty
  a_trig_nostore: assert property (p_trig_nostore) else $error("trigger write stored");

  property p_trig_read_zero;
    @(posedge clk_i) disable iff (reset_i)
      (req && !wb_we_i && hit_rt) |=> (wb_dat_o == '0);
  endproperty
  a_trig_read_zero: assert property (p_trig_read_zero) else $error("trigger reads data");

  property p_cab_store;
    @(posedge clk_i) disable iff (reset_i)
      (wr && hit_sr) |=> (s_r.cab == $past(wb_dat_i[B_CAB_HI:B_CAB_LO]));
  endproperty
  a_cab_store: assert property (p_cab_store) else $error("cabinet select not stored");

  property p_cab_main;
    @(posedge clk_i) disable iff (reset_i)
      (s_r.cab == CMMC_CAB_MAIN) |-> (cab_tx_o == {2'h3, ps_tx_i} && ps_rx_o == cab_rx_i[0]);
  endproperty
  a_cab_main: assert property (p_cab_main) else $error("main cabinet routing wrong");

  property p_pwr_b_live;
    @(posedge clk_i) disable iff (reset_i)
      (req && !wb_we_i && hit_sr) |=> (wb_dat_o[B_PWR_B] == $past(pwr_b_s));
  endproperty
  a_pwr_b_live: assert property (p_pwr_b_live) else $error("power B not live");

  property p_srom_oe;
    @(posedge clk_i) disable iff (reset_i)
      (wr && hit_sr) |=> (serial_rom_data_oe_o == !$past(wb_dat_i[B_SROM_TX]));
  endproperty
  a_srom_oe: assert property (p_srom_oe) else $error("serial data enable wrong");

  property p_serial_rom_clock_bit;
    @(posedge clk_i) disable iff (reset_i)
      (wr && hit_sr) |=> (serial_rom_clock_o == $past(wb_dat_i[B_SERIAL_ROM_CLOCK_BIT]));
  endproperty
  a_serial_rom_clock_bit: assert property (p_serial_rom_clock_bit) else $error("serial clock wrong");

  property p_srom_rx;
    @(posedge clk_i) disable iff (reset_i)
      (req && !wb_we_i && hit_sr) |=> (wb_dat_o[B_SROM_RX] == $past(srom_rx_s));
  endproperty
  a_srom_rx: assert property (p_srom_rx) else $error("serial data read wrong");

  property p_irq_set;
    @(posedge clk_i) disable iff (reset_i)
      (s_r.pf_irq_en && $changed(pwr_a_s)) |=> power_fail_irq_o;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("power fail not flagged");

  property p_irq_clear;
    @(posedge clk_i) disable iff (reset_i)
      (wr && hit_sr && !wb_dat_i[B_PWR_A] && !(s_r.pf_irq_en && $changed(pwr_a_s)))
        |=> !power_fail_irq_o;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("power fail not cleared");

  c_reset_seq: cover property (@(posedge clk_i) $rose(backplane_reset_line_o));
  c_irq: cover property (@(posedge clk_i) $rose(power_fail_irq_o));
  c_loop: cover property (@(posedge clk_i) s_r.cab == CMMC_CAB_LOOP);
  c_err: cover property (@(posedge clk_i) wb_err_o);
  c_srom_read: cover property (@(posedge clk_i) req && !wb_we_i && hit_sr);
endmodule : cmmc_top

// ### cmmc_srom_model.sv
// Behavioural serial ROM on the open-drain data line of the control bank.
// Assumes the bank's clock bit and data enable; line has a pull-up.
`timescale 1ns/1ps
module cmmc_srom_model #(
  parameter logic [7:0] PATTERN = 8'hA5
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic serial_rom_clock_bit_i,
  input  wire logic host_oe_i,
  output logic      line_o
);
  logic [2:0] idx_r;
  logic       last_clk_r;
  // Either party pulls low, pull-up otherwise
  assign line_o = !host_oe_i && PATTERN[3'h7 - idx_r];
  // Steps only on a clock rise made by software writes
  always @(posedge clk_i) begin
    last_clk_r <= serial_rom_clock_bit_i;
    if (reset_i)
      idx_r <= 3'h0;
    else if (serial_rom_clock_bit_i && !last_clk_r)
      idx_r <= idx_r + 3'h1;
  end
endmodule : cmmc_srom_model

// ### tb_cpu_module_misc_control.sv
// Self-checking bench for the miscellaneous control bank.
// Assumes cmmc_pkg and the serial ROM model are compiled first.
`timescale 1ns/1ps
module tb_cpu_module_misc_control;
  import cmmc_pkg::*;
  typedef struct {logic w; logic [39:0] a; logic [7:0] d; logic [7:0] q; logic e;} cmmc_row_t;
  localparam logic [7:0] SROM_PATTERN = 8'hA5;
  logic clk_i = 0, reset_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [39:0] wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic [3:0]  wb_sel_i = 4'h1;
  logic [2:0]  cab_tx_o, cab_rx_i = 3'h7, m;
  logic wb_ack_o, wb_err_o, flash_wr_o, serial_rom_data_i, serial_rom_data_oe_o, e;
  logic flash_wr_req_i = 1, run_line_i = 1, secure_line_i = 0;
  logic power_unit_a_i = 1, power_unit_b_status_i = 0, ps_tx_i = 0, ps_rx_o;
  logic serial_rom_clock_o, console_owner_line_drive_o, run_line_drive_o, local_reset_o;
  logic backplane_failed_module_line_o, backplane_reset_line_o;
  logic selftest_passed_led_o, power_fail_irq_o;
  int n_errors = 0, tests_run = 0, cyc = 0, n;
  cmmc_row_t rows[9] = '{
    '{1'h1, MISC_LINE_DRIVE_ADDR, 8'hFC, 8'h00, 1'h0},
    '{1'h0, MISC_READBACK_ADDR, 8'h00, 8'hD0, 1'h0},
    '{1'h1, MISC_READBACK_ADDR, 8'hFF, 8'h00, 1'h0},
    '{1'h0, MISC_READBACK_ADDR, 8'h00, 8'hD0, 1'h0},
    '{1'h0, MISC_LINE_DRIVE_ADDR, 8'h00, 8'h00, 1'h0},
    '{1'h0, SYS_RESET_TRIG_ADDR, 8'h00, 8'h00, 1'h0},
    '{1'h0, 40'hFFC8000000, 8'h00, 8'h00, 1'h1},
    '{1'h1, SROM_POWER_ADDR, 8'h84, 8'h00, 1'h0},
    '{1'h0, SROM_POWER_ADDR, 8'h00, 8'hC2, 1'h0}};

  cmmc_top dut (.clk_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .flash_wr_req_i, .flash_wr_o, .run_line_i,
    .secure_line_i, .power_unit_a_i, .power_unit_b_status_i, .serial_rom_data_i,
    .serial_rom_data_o(), .serial_rom_data_oe_o, .serial_rom_clock_o,
    .console_owner_line_drive_o, .run_line_drive_o, .backplane_failed_module_line_o,
    .local_reset_o, .backplane_reset_line_o, .selftest_passed_led_o, .power_fail_irq_o,
    .ps_tx_i, .ps_rx_o, .cab_tx_o, .cab_rx_i);
  cmmc_srom_model #(.PATTERN(SROM_PATTERN)) rom (.clk_i, .reset_i,
    .serial_rom_clock_bit_i(serial_rom_clock_o), .host_oe_i(serial_rom_data_oe_o),
    .line_o(serial_rom_data_i));

  always #5 clk_i = ~clk_i;

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk

  // Entered just after a rising edge; waits for the answer, no fixed latency
  task automatic bus(input logic w, input logic [39:0] a, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  // Whole run needs about 1900 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    chk({flash_wr_o, console_owner_line_drive_o, run_line_drive_o, selftest_passed_led_o,
      backplane_failed_module_line_o, local_reset_o, backplane_reset_line_o,
      serial_rom_clock_o, serial_rom_data_oe_o, power_fail_irq_o}, 10'h004);
    done("reset");
    @(posedge clk_i);
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      chk(e, rows[i].e);
      if (!rows[i].w) chk(q, {24'h000000, rows[i].q});
    end
    #1;
    chk({console_owner_line_drive_o, run_line_drive_o, backplane_failed_module_line_o,
      flash_wr_o, selftest_passed_led_o}, 5'h1F);
    @(posedge clk_i);
    bus(1'b1, MISC_LINE_DRIVE_ADDR, 8'h00);
    #1;
    chk({console_owner_line_drive_o, run_line_drive_o, backplane_failed_module_line_o,
      flash_wr_o, selftest_passed_led_o}, 5'h01);
    @(posedge clk_i);
    wb_sel_i <= 4'h0;
    bus(1'b1, MISC_LINE_DRIVE_ADDR, 8'hFC);
    wb_sel_i <= 4'h1;
    #1;
    chk({console_owner_line_drive_o, flash_wr_o}, 2'h0);
    done("table");
    @(posedge clk_i);
    for (int i = 6; i >= 0; i--) begin
      bus(1'b1, SROM_POWER_ADDR, 8'h04);
      bus(1'b1, SROM_POWER_ADDR, 8'h05);
      repeat (3) @(posedge clk_i);
      bus(1'b0, SROM_POWER_ADDR, 8'h00);
      chk(q[1], SROM_PATTERN[i]);
    end
    bus(1'b1, SROM_POWER_ADDR, 8'h01);
    repeat (3) @(posedge clk_i);
    bus(1'b0, SROM_POWER_ADDR, 8'h00);
    chk({q[1], serial_rom_data_oe_o}, 2'h1);
    done("serial");
    for (int c = 0; c < 4; c++) begin
      m = (c == 3) ? 3'h7 : ~(3'h1 << c);
      bus(1'b1, SROM_POWER_ADDR, {3'h0, c[1:0], 3'h4});
      cab_rx_i <= m;
      #1;
      chk({ps_rx_o, cab_tx_o}, {1'h0, m});
      @(posedge clk_i);
    end
    done("cabinet");
    bus(1'b1, SROM_POWER_ADDR, 8'h44);
    power_unit_a_i <= 1'b0;
    power_unit_b_status_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    bus(1'b0, SROM_POWER_ADDR, 8'h00);
    chk({q[6], q[5], power_fail_irq_o}, 3'h3);
    bus(1'b1, SROM_POWER_ADDR, 8'h04);
    power_unit_a_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1;
    chk(power_fail_irq_o, 1'h0);
    done("power");
    @(posedge clk_i);
    bus(1'b1, SYS_RESET_TRIG_ADDR, 8'h5A);
    #1;
    // Two local reset cycles pass inside the bus task
    n = 2;
    while (local_reset_o === 1'b1) begin
      n++;
      @(posedge clk_i);
      #1;
    end
    chk(n, LOCAL_RST_CYCLES);
    n = 0;
    while (backplane_reset_line_o === 1'b1) begin
      n++;
      @(posedge clk_i);
      #1;
    end
    chk(n, BP_RST_CYCLES);
    done("reset sequence");
    results();
  end
endmodule : tb_cpu_module_misc_control
